/* File: hdl/fcd_pkg.sv */
package fcd_pkg;
    // clock and timing
    localparam longint CLK_HZ          = 25_000_000;
    localparam longint SHUNT_HOLD_MIN  = 5;
    localparam longint SHUNT_HOLD_CYC  = SHUNT_HOLD_MIN * 60 * CLK_HZ;
    localparam longint CONFIRM_MS      = 10;
    localparam longint CONFIRM_CYC     = (CONFIRM_MS * CLK_HZ) / 1000;
    localparam int     SHUNT_W         = 34;
    localparam int     CONFIRM_W       = 20;

    // incoming control byte fields
    localparam int     CTL_TORQUE_BIT  = 0;
    localparam int     CTL_ANGLE_BIT   = 1;
    localparam int     CTL_SHUNT_BIT   = 2;
    localparam int     SEL_W           = 7;

    // selection codes
    localparam logic [6:0] SEL_NONE    = 7'h00;
    localparam logic [6:0] SEL_FIRST   = 7'h01;
    localparam logic [6:0] SEL_LAST    = 7'h20;
    localparam logic [6:0] SEL_RES_LO  = 7'h21;
    localparam logic [6:0] SEL_RES_HI  = 7'h3e;
    localparam logic [6:0] SEL_FACTORY = 7'h3f;

    // register map, byte addresses
    localparam logic [7:0] ADDR_CONTROL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h10;
    localparam logic [7:0] CONTROL_RESET   = 8'h01;
    localparam int         CONTROL_EN_BIT  = 0;

    // interrupt event bits
    localparam int IRQ_W          = 6;
    localparam int EV_TORQUE      = 0;
    localparam int EV_ANGLE       = 1;
    localparam int EV_SHUNT_TMO   = 2;
    localparam int EV_LOAD        = 3;
    localparam int EV_INVALID     = 4;
    localparam int EV_MISMATCH    = 5;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_ON   = 2'b01,
        SH_WAIT = 2'b10
    } fcd_shunt_t;
endpackage

/* File: hdl/fcd_decoder.sv */
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module fcd_decoder
    import fcd_pkg::*;
#(
    parameter logic [SHUNT_W-1:0]   SHUNT_CYCLES   = SHUNT_W'(SHUNT_HOLD_CYC),
    parameter logic [CONFIRM_W-1:0] CONFIRM_CYCLES = CONFIRM_W'(CONFIRM_CYC)
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    // fieldbus process data in
    input  wire logic               fb_cycle,
    input  wire logic [7:0]         fb_ctrl_byte,
    input  wire logic [7:0]         fb_param_byte,
    // measurement and parameter store side
    input  wire logic               torque_zero_done,
    input  wire logic               angle_zero_done,
    input  wire logic               sel_blocked,
    input  wire logic               web_editing,
    input  wire logic               param_load_done,
    output logic                    zero_torque_req,
    output logic                    zero_angle_req,
    output logic                    shunt_on,
    output logic                    param_load,
    output logic                    factory_load,
    output logic [SEL_W-1:0]        param_sel,
    // fieldbus status out
    output logic                    torque_confirm,
    output logic                    angle_confirm,
    output logic [SEL_W-1:0]        active_set,
    output logic                    sel_lock,
    output logic                    invalid_flag,
    output logic                    mismatch_flag,
    output logic                    irq,
    // axi4-lite slave
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);

    function automatic logic sel_loadable(input logic [6:0] s);
        return (s >= SEL_FIRST && s <= SEL_LAST) || s == SEL_FACTORY;
    endfunction

    function automatic logic sel_invalid(input logic [6:0] s);
        return s > SEL_LAST && s != SEL_FACTORY && !(s >= SEL_RES_LO && s <= SEL_RES_HI);
    endfunction

    logic [7:0]             control;
    logic [7:0]             ctrl_q;
    logic [7:0]             param_q;
    logic [IRQ_W-1:0]       irq_status;
    logic [IRQ_W-1:0]       irq_enable;
    logic [IRQ_W-1:0]       events;
    fcd_shunt_t             shunt_state;
    logic [SHUNT_W-1:0]     shunt_cnt;
    logic [CONFIRM_W-1:0]   torque_cnt;
    logic [CONFIRM_W-1:0]   angle_cnt;
    logic [SEL_W-1:0]       pending_set;
    logic [7:0]             aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   aw_got;
    logic                   w_got;
    logic                   sample;
    logic                   torque_rise;
    logic                   angle_rise;
    logic                   shunt_rise;
    logic                   shunt_drop;
    logic                   sel_change;
    logic                   wr_fire;
    logic                   wr_byte0;

    assign sample      = fb_cycle && control[CONTROL_EN_BIT];
    // reserved control bits 3..7 never reach any decode
    assign torque_rise = sample && fb_ctrl_byte[CTL_TORQUE_BIT] && !ctrl_q[CTL_TORQUE_BIT];
    assign angle_rise  = sample && fb_ctrl_byte[CTL_ANGLE_BIT] && !ctrl_q[CTL_ANGLE_BIT];
    assign shunt_rise  = sample && fb_ctrl_byte[CTL_SHUNT_BIT] && !ctrl_q[CTL_SHUNT_BIT];
    assign shunt_drop  = sample && !fb_ctrl_byte[CTL_SHUNT_BIT];
    assign sel_change  = sample && fb_param_byte[SEL_W-1:0] != param_q[SEL_W-1:0];
    assign wr_fire     = aw_got && w_got && !s_axi_bvalid;
    assign wr_byte0    = wr_fire && w_strb[0];

    // previous fieldbus bytes, one sample per bus cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= 8'h00;
            param_q <= 8'h00;
        end else if (sample) begin
            ctrl_q  <= fb_ctrl_byte;
            param_q <= fb_param_byte;
        end
    end

    // zeroing requests: one pulse per rising bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            zero_torque_req <= 1'b0;
            zero_angle_req  <= 1'b0;
        end else begin
            zero_torque_req <= torque_rise;
            zero_angle_req  <= angle_rise;
        end
    end

    // shunt: fire on rise, drop on timeout or withdrawal, rearm after withdrawal
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shunt_state <= SH_IDLE;
            shunt_cnt   <= '0;
            shunt_on    <= 1'b0;
        end else begin
            unique case (shunt_state)
                SH_IDLE: begin
                    if (shunt_rise) begin
                        shunt_state <= SH_ON;
                        shunt_cnt   <= SHUNT_CYCLES;
                        shunt_on    <= 1'b1;
                    end
                end
                SH_ON: begin
                    if (shunt_drop) begin
                        shunt_state <= SH_IDLE;
                        shunt_on    <= 1'b0;
                    end else if (shunt_cnt <= SHUNT_W'(1)) begin
                        shunt_state <= SH_WAIT;
                        shunt_on    <= 1'b0;
                    end else begin
                        shunt_cnt <= shunt_cnt - SHUNT_W'(1);
                    end
                end
                SH_WAIT: begin
                    // a held request must be withdrawn before the next fires
                    if (shunt_drop) begin
                        shunt_state <= SH_IDLE;
                    end
                end
                default: begin
                    shunt_state <= SH_IDLE;
                    shunt_on    <= 1'b0;
                end
            endcase
        end
    end

    // parameter selection: load once per change when allowed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            param_load   <= 1'b0;
            factory_load <= 1'b0;
            param_sel    <= '0;
            pending_set  <= '0;
        end else begin
            param_load   <= 1'b0;
            factory_load <= 1'b0;
            // refused loads are not retried; the mismatch flag shows it
            if (sel_change && sel_loadable(fb_param_byte[SEL_W-1:0])
                && !sel_blocked && !web_editing) begin
                param_load   <= 1'b1;
                factory_load <= fb_param_byte[SEL_W-1:0] == SEL_FACTORY;
                param_sel    <= fb_param_byte[SEL_W-1:0];
                pending_set  <= fb_param_byte[SEL_W-1:0];
            end
        end
    end

    // returned set number and status flags
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            active_set    <= '0;
            sel_lock      <= 1'b0;
            invalid_flag  <= 1'b0;
            mismatch_flag <= 1'b0;
        end else begin
            if (param_load_done) begin
                active_set <= pending_set;
            end
            sel_lock      <= sel_blocked || web_editing;
            invalid_flag  <= sel_invalid(param_q[SEL_W-1:0]);
            mismatch_flag <= param_q[SEL_W-1:0] != active_set;
        end
    end

    // completion confirmation pulses
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            torque_cnt     <= '0;
            angle_cnt      <= '0;
            torque_confirm <= 1'b0;
            angle_confirm  <= 1'b0;
        end else begin
            if (torque_zero_done) begin
                torque_cnt <= CONFIRM_CYCLES;
            end else if (torque_cnt != '0) begin
                torque_cnt <= torque_cnt - CONFIRM_W'(1);
            end
            if (angle_zero_done) begin
                angle_cnt <= CONFIRM_CYCLES;
            end else if (angle_cnt != '0) begin
                angle_cnt <= angle_cnt - CONFIRM_W'(1);
            end
            torque_confirm <= torque_zero_done || torque_cnt > CONFIRM_W'(1);
            angle_confirm  <= angle_zero_done || angle_cnt > CONFIRM_W'(1);
        end
    end

    // interrupts: set wins over clear
    always_comb begin
        events               = '0;
        events[EV_TORQUE]    = torque_rise;
        events[EV_ANGLE]     = angle_rise;
        events[EV_SHUNT_TMO] = shunt_state == SH_ON && !shunt_drop && shunt_cnt <= SHUNT_W'(1);
        events[EV_LOAD]      = param_load;
        events[EV_INVALID]   = sel_invalid(param_q[SEL_W-1:0]) && !invalid_flag;
        events[EV_MISMATCH]  = param_q[SEL_W-1:0] != active_set && !mismatch_flag;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            if (wr_byte0 && aw_addr == ADDR_IRQ_CLEAR) begin
                irq_status <= (irq_status & ~w_data[IRQ_W-1:0]) | events;
            end else begin
                irq_status <= irq_status | events;
            end
            irq <= |(irq_status & irq_enable);
        end
    end

    // software registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            control    <= CONTROL_RESET;
            irq_enable <= '0;
        end else if (wr_byte0) begin
            if (aw_addr == ADDR_CONTROL) begin
                control <= w_data[7:0];
            end
            if (aw_addr == ADDR_IRQ_ENABLE) begin
                irq_enable <= w_data[IRQ_W-1:0];
            end
        end
    end

    // axi write channel: address and data in either order
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_got        <= 1'b1;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_got        <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == ADDR_CONTROL || aw_addr == ADDR_IRQ_ENABLE
                                 || aw_addr == ADDR_IRQ_CLEAR) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got        <= 1'b0;
                w_got         <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // axi read channel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_CONTROL:    s_axi_rdata <= {24'h00_0000, control};
                ADDR_STATUS:     s_axi_rdata <= {8'h00, 1'b0, active_set, param_q,
                                                 sel_lock, invalid_flag, mismatch_flag,
                                                 shunt_state, shunt_on,
                                                 torque_confirm, angle_confirm};
                ADDR_IRQ_STATUS: s_axi_rdata <= {26'h000_0000, irq_status};
                ADDR_IRQ_ENABLE: s_axi_rdata <= {26'h000_0000, irq_enable};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_shunt_fire;
        shunt_state == SH_IDLE && shunt_rise;
    endsequence

    sequence s_shunt_held;
        shunt_on && !shunt_drop;
    endsequence

    AST_TORQUE_EDGE: assert property (torque_rise |=> zero_torque_req ##1 !zero_torque_req)
        else $error("torque zeroing pulse wrong");
    AST_ANGLE_EDGE: assert property ($rose(zero_angle_req) |-> $past(angle_rise))
        else $error("angle zeroing without rising request");
    AST_SHUNT_FIRE: assert property (s_shunt_fire |=> shunt_on && shunt_cnt == SHUNT_CYCLES)
        else $error("shunt did not fire");
    AST_SHUNT_DROP: assert property (shunt_on && shunt_drop |=> !shunt_on)
        else $error("shunt not released on withdrawal");
    AST_SHUNT_TMO: assert property (s_shunt_held ##0 shunt_cnt == SHUNT_W'(1) |=> !shunt_on)
        else $error("shunt not released on timeout");
    AST_SHUNT_REARM: assert property ($rose(shunt_on) |-> $past(shunt_state) == SH_IDLE)
        else $error("shunt fired without rearm");
    AST_LOAD_OK: assert property (sel_change && sel_loadable(fb_param_byte[SEL_W-1:0])
        && !sel_blocked && !web_editing |=> param_load && param_sel == $past(fb_param_byte[SEL_W-1:0]))
        else $error("valid selection not loaded");
    AST_LOAD_BLOCK: assert property (param_load |-> $past(!sel_blocked && !web_editing && sel_change))
        else $error("load while blocked or unchanged");
    AST_NO_FUNC: assert property (param_load |-> sel_loadable(param_sel))
        else $error("load of a no-function selection");
    AST_FACTORY: assert property (factory_load |-> param_load && param_sel == SEL_FACTORY)
        else $error("factory load code wrong");
    AST_MISMATCH: assert property (##1 mismatch_flag == ($past(param_q[SEL_W-1:0]) != $past(active_set)))
        else $error("mismatch flag wrong");
    AST_CONFIRM: assert property (torque_zero_done |=> torque_confirm [*2])
        else $error("torque confirm pulse too short");
    AST_LOCK: assert property (##1 sel_lock == $past(sel_blocked || web_editing))
        else $error("lock bit wrong");

endmodule

/* File: tb/fcd_fb_master.sv */
`timescale 1ns/100ps
module fcd_fb_master (
    // clock
    input  wire logic       clock,
    // cyclic process data
    output logic            fb_cycle,
    output logic [7:0]      fb_ctrl_byte,
    output logic [7:0]      fb_param_byte
);
    initial begin
        fb_cycle = 1'b0;
        fb_ctrl_byte = 8'h00;
        fb_param_byte = 8'h00;
    end

    // bytes stay as cyclic data; raw lets a test drive reserved bits on purpose
    task automatic send(input logic [7:0] c, input logic [7:0] p, input bit raw);
        @(posedge clock);
        fb_cycle <= 1'b1;
        fb_ctrl_byte <= raw ? c : (c & 8'h07);
        fb_param_byte <= raw ? p : (p & 8'h7f);
        @(posedge clock);
        fb_cycle <= 1'b0;
    endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench
    import fcd_pkg::*;
;
    localparam int CF = 4;
    logic clock, rst_n, fb_cycle, tz_d, az_d, sel_blocked, web_editing, pl_d;
    logic [7:0] fb_ctrl_byte, fb_param_byte, awaddr, araddr;
    logic ztr, zar, shunt_on, param_load, factory_load, tconf, aconf, sel_lock;
    logic invalid_flag, mismatch_flag, irq, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [6:0] param_sel, active_set;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp;
    int n_fail, samples_checked, n_tz, n_az, n_pl, n_fl, n_tc, n_ac, pl0;
    logic [7:0] sels [9] = '{8'h01, 8'h20, 8'h00, 8'h21, 8'h3e, 8'h3f, 8'h40, 8'h7f, 8'h20};
    logic [6:0] act;
    bit ld;

    fcd_fb_master fcd_fb_master_i (.clock(clock), .fb_cycle(fb_cycle),
        .fb_ctrl_byte(fb_ctrl_byte), .fb_param_byte(fb_param_byte));

    fcd_decoder #(.SHUNT_CYCLES(34'd20), .CONFIRM_CYCLES(20'd4)) fcd_decoder_i (
        .clock(clock), .rst_n(rst_n), .fb_cycle(fb_cycle), .fb_ctrl_byte(fb_ctrl_byte),
        .fb_param_byte(fb_param_byte), .torque_zero_done(tz_d), .angle_zero_done(az_d),
        .sel_blocked(sel_blocked), .web_editing(web_editing), .param_load_done(pl_d),
        .zero_torque_req(ztr), .zero_angle_req(zar), .shunt_on(shunt_on),
        .param_load(param_load), .factory_load(factory_load), .param_sel(param_sel),
        .torque_confirm(tconf), .angle_confirm(aconf), .active_set(active_set),
        .sel_lock(sel_lock), .invalid_flag(invalid_flag), .mismatch_flag(mismatch_flag),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr));

    always #20 clock = ~clock;

    // count on the falling edge so the main sequence never races the tally
    always @(negedge clock) begin
        n_tz += int'(ztr);
        n_az += int'(zar);
        n_pl += int'(param_load);
        n_fl += int'(factory_load);
        n_tc += int'(tconf);
        n_ac += int'(aconf);
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge clock);
        awaddr <= a;
        wdata <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clock);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!(bv && br));
        check("bresp", 32'(er), 32'(bresp));
        br <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        @(posedge clock);
        araddr <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clock);
            if (arv && arr) arv <= 1'b0;
        end while (!(rv && rr));
        v = rdata;
        check("rresp", 32'(er), 32'(rresp));
        rr <= 1'b0;
    endtask

    task automatic frame(input logic [7:0] c, input logic [7:0] p, input bit raw = 0);
        fcd_fb_master_i.send(c, p, raw);
        repeat (4) @(posedge clock);
    endtask

    initial begin
        #(40 * 4000);
        n_fail++;
        final_report();
    end

    initial begin
        {clock, rst_n, tz_d, az_d, sel_blocked, web_editing, pl_d} = '0;
        {awv, wv, br, arv, rr, awaddr, araddr, wdata} = '0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        axr(ADDR_CONTROL, d, RESP_OKAY);
        check("control", 32'h1, d);
        frame(8'h01, 8'h00);
        frame(8'h01, 8'h00);
        check("tz_cnt", 1, n_tz);
        frame(8'h03, 8'h00);
        check("az_cnt", 1, n_az);
        frame(8'h00, 8'h00);
        frame(8'hf8, 8'h00, 1);
        check("rsv", 32'h0001_0010, {n_tz[15:0], n_az[11:0], 3'b0, shunt_on});
        @(posedge clock) {tz_d, az_d} <= 2'b11;
        @(posedge clock) {tz_d, az_d} <= 2'b00;
        repeat (8) @(posedge clock);
        check("confirm", CF, n_tc);
        check("aconfirm", CF, n_ac);
        axw(ADDR_IRQ_CLEAR, 32'h3f, RESP_OKAY);
        axw(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
        check("irq_idle", 0, 32'(irq));
        frame(8'h00, 8'h00);
        frame(8'h01, 8'h00);
        check("irq_set", 1, 32'(irq));
        axr(ADDR_IRQ_STATUS, d, RESP_OKAY);
        check("irq_st", 32'h1, d);
        axw(ADDR_IRQ_ENABLE, 32'h0, RESP_OKAY);
        repeat (3) @(posedge clock);
        check("irq_mask", 0, 32'(irq));
        axw(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
        axw(ADDR_IRQ_CLEAR, 32'h1, RESP_OKAY);
        repeat (3) @(posedge clock);
        check("irq_clr", 0, 32'(irq));
        axr(8'h40, d, RESP_SLVERR);
        axw(8'h40, 32'h1, RESP_SLVERR);
        frame(8'h04, 8'h00);
        check("sh_on", 1, 32'(shunt_on));
        frame(8'h04, 8'h00);
        check("sh_held", 1, 32'(shunt_on));
        repeat (20) @(posedge clock);
        check("sh_tmo", 0, 32'(shunt_on));
        frame(8'h04, 8'h00);
        check("sh_rearm", 0, 32'(shunt_on));
        frame(8'h00, 8'h00);
        frame(8'h04, 8'h00);
        check("sh_again", 1, 32'(shunt_on));
        frame(8'h00, 8'h00);
        check("sh_wd", 0, 32'(shunt_on));
        act = 7'h00;
        foreach (sels[i]) begin
            pl0 = n_pl;
            ld = (sels[i] >= 8'h01 && sels[i] <= 8'h20) || sels[i] == 8'h3f;
            frame(8'h00, sels[i]);
            check("load", 32'(ld), n_pl - pl0);
            check("inv", 32'(sels[i] >= 8'h40), 32'(invalid_flag));
            if (ld) begin
                check("psel", 32'(sels[i]), 32'(param_sel));
                @(posedge clock) pl_d <= 1'b1;
                @(posedge clock) pl_d <= 1'b0;
                act = sels[i][6:0];
                repeat (3) @(posedge clock);
            end
            check("mis", 32'(sels[i][6:0] != act), 32'(mismatch_flag));
            check("act", 32'(act), 32'(active_set));
        end
        check("factory", 1, n_fl);
        axr(ADDR_STATUS, d, RESP_OKAY);
        check("status", 32'h0020_2000, d);
        pl0 = n_pl;
        frame(8'h00, 8'h20);
        sel_blocked <= 1'b1;
        frame(8'h00, 8'h07);
        check("lock", 1, 32'(sel_lock));
        check("mis_blk", 1, 32'(mismatch_flag));
        sel_blocked <= 1'b0;
        web_editing <= 1'b1;
        frame(8'h00, 8'h09);
        check("blk_cnt", pl0, n_pl);
        web_editing <= 1'b0;
        frame(8'h00, 8'h0a);
        check("unlock", 32'h00a, {sel_lock, 1'b0, param_sel});
        check("ok_cnt", pl0 + 1, n_pl);
        final_report();
    end
endmodule
